// file: cpev_core.sv
// Fetch, three-stage pipeline, execution and exception vectoring of a 16-bit core.
// Assumes the bus integration module shares MCLK and acks a cycle no earlier than its second clock.
`timescale 1ns/1ps
module cpev_core (
  input wire logic MCLK,
  input wire logic RESET,
  output logic BUS_REQ,
  output logic BUS_WE,
  output logic BUS_PROG,
  output logic [cpev_pkg::AW-1:0] BUS_ADDR,
  output logic [cpev_pkg::DW-1:0] BUS_WDATA,
  input wire logic [cpev_pkg::DW-1:0] BUS_RDATA,
  input wire logic BUS_ACK,
  input wire logic BKPT_N,
  input wire logic BERR_N,
  input wire logic [2:0] IRQ_LEVEL,
  input wire logic [7:0] IRQ_VEC,
  input wire logic IRQ_AUTOVEC,
  output logic PIPE_TRACK_OUT_A,
  output logic PIPE_TRACK_OUT_B,
  output logic EXC_TAKEN,
  output logic [7:0] EXC_VECTOR
);
  import cpev_pkg::*;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  cpev_ex_e st_reg;
  logic [4:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg, pin_prev_reg;
  logic bkpt_pend_reg, berr_pend_reg;
  logic bus_busy_reg, bus_fetch_reg, discard_reg;
  logic [2:0] bus_cnt_reg;
  logic bus_done, ex_done, fetch_done, fetch_go;
  logic ex_req_reg, ex_we_reg, ex_prog_reg;
  logic [AW-1:0] ex_addr_reg;
  logic [DW-1:0] ex_wdata_reg;
  logic [15:0] pc_reg, pc_load_val, stack_pointer_reg, direct_page_index_reg, condition_code_reg;
  logic [3:0] stack_bank_ext_reg, z_index_bank_ext_reg;
  logic [1:0] rst_idx_reg, cnt_reg;
  logic [7:0] vec_reg;
  logic [2:0] lvl_reg;
  logic irq_take_reg, pc_load, purge;
  logic hold_v_reg;
  logic [STW-1:0] hold_reg, a_q, b_q, c_q;
  logic a_v, b_v, c_v, hold_to_a, a_to_b, b_retire;
  logic [7:0] op, opnd, exc_vec, async_vec;
  logic is_jmp, is_swi, is_div, sync_exc, intop_end;
  logic [2:0] irq_lvl;
  logic irq_go, take_async, start_ok, exc_go;
  logic [15:0] exc_stk;
  logic [4:0] ev, ev_reg;
  logic phase_reg, track_a_reg, track_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pin_s1_reg <= PIN_RST;
      pin_s2_reg <= PIN_RST;
      pin_s3_reg <= PIN_RST;
      pin_reg <= PIN_RST;
    end else begin
      pin_s1_reg <= {BKPT_N, BERR_N, IRQ_LEVEL};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg) begin
        pin_reg <= pin_s3_reg;
      end
    end
  end
  assign irq_lvl = pin_reg[2:0];

  // Breakpoint and bus error are edge events held until taken; a new edge beats the clear
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pin_prev_reg <= PIN_RST;
      bkpt_pend_reg <= 1'b0;
      berr_pend_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_reg;
      bkpt_pend_reg <= (pin_prev_reg[4] & ~pin_reg[4]) | (bkpt_pend_reg & ~take_async);
      berr_pend_reg <= (pin_prev_reg[3] & ~pin_reg[3]) | (berr_pend_reg & ~(take_async & ~bkpt_pend_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine: execution requests win over prefetch; an ack before the
  // second clock is not accepted, so no cycle is ever shorter than two clocks
  assign bus_done = bus_busy_reg && BUS_ACK && (bus_cnt_reg >= BUS_MIN_CLKS - 3'h1);
  assign ex_done = bus_done && !bus_fetch_reg;
  assign fetch_done = bus_done && bus_fetch_reg;
  assign fetch_go = !bus_busy_reg && !ex_req_reg && !hold_v_reg && !purge &&
                    (st_reg == EX_IDLE || st_reg == EX_INTOP);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      bus_busy_reg <= 1'b0;
      bus_fetch_reg <= 1'b0;
      bus_cnt_reg <= 3'h0;
      BUS_REQ <= 1'b0;
      BUS_WE <= 1'b0;
      BUS_PROG <= 1'b0;
      BUS_ADDR <= '0;
      BUS_WDATA <= '0;
    end else if (bus_done) begin
      bus_busy_reg <= 1'b0;
      BUS_REQ <= 1'b0;
    end else if (bus_busy_reg) begin
      if (bus_cnt_reg != 3'h7) begin
        bus_cnt_reg <= bus_cnt_reg + 3'h1;
      end
    end else if (ex_req_reg) begin
      bus_busy_reg <= 1'b1;
      bus_fetch_reg <= 1'b0;
      bus_cnt_reg <= 3'h0;
      BUS_REQ <= 1'b1;
      BUS_WE <= ex_we_reg;
      BUS_PROG <= ex_prog_reg;
      BUS_ADDR <= ex_addr_reg;
      BUS_WDATA <= ex_wdata_reg;
    end else if (fetch_go) begin
      bus_busy_reg <= 1'b1;
      bus_fetch_reg <= 1'b1;
      bus_cnt_reg <= 3'h0;
      BUS_REQ <= 1'b1;
      BUS_WE <= 1'b0;
      BUS_PROG <= 1'b1;
      BUS_ADDR <= {condition_code_reg[COND_PBANK_LSB +: 4], pc_reg};
    end
  end

  // Program counter moves as each fetch is issued, so it runs ahead of execution
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pc_reg <= 16'h0000;
    end else if (pc_load) begin
      pc_reg <= pc_load_val;
    end else if (fetch_go) begin
      pc_reg <= pc_reg + WORD_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prefetch landing word; a fetch that was in flight during a purge is dropped
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      hold_v_reg <= 1'b0;
      hold_reg <= '0;
      discard_reg <= 1'b0;
    end else begin
      if (purge && bus_busy_reg && bus_fetch_reg && !fetch_done) begin
        discard_reg <= 1'b1;
      end else if (fetch_done) begin
        discard_reg <= 1'b0;
      end
      if (purge) begin
        hold_v_reg <= 1'b0;
      end else if (fetch_done && !discard_reg) begin
        hold_v_reg <= 1'b1;
        hold_reg <= {BUS_ADDR, BUS_RDATA};
      end else if (hold_to_a) begin
        hold_v_reg <= 1'b0;
      end
    end
  end

  // Stage moves happen whenever there is room and no purge, independent of execution
  assign purge = pc_load;
  assign a_to_b = a_v && (!b_v || b_retire) && !purge;
  assign hold_to_a = hold_v_reg && (!a_v || a_to_b) && !purge;

  // Three-stage FIFO: A latches, B decodes and executes, C keeps the last finished opcode
  cpev_stage #(.W(STW)) u_stage_a (
    .clk(MCLK), .rst(RESET), .clr(purge), .load(hold_to_a), .take(a_to_b),
    .d(hold_reg), .q(a_q), .valid(a_v)
  );
  cpev_stage #(.W(STW)) u_stage_b (
    .clk(MCLK), .rst(RESET), .clr(purge), .load(a_to_b), .take(b_retire),
    .d(a_q), .q(b_q), .valid(b_v)
  );
  cpev_stage #(.W(STW)) u_stage_c (
    .clk(MCLK), .rst(RESET), .clr(1'b0), .load(b_retire), .take(1'b0),
    .d(b_q), .q(c_q), .valid(c_v)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode in stage B; the byte operand rides with the opcode, word operands come from A
  assign op = b_q[15:8];
  assign opnd = b_q[7:0];
  assign is_jmp = (op == OP_JMP);
  assign is_swi = (op == OP_SWI);
  assign is_div = (op == OP_DIV);
  assign sync_exc = is_swi || (is_div && opnd == 8'h00) || !(is_jmp || is_div || op == OP_NOP);
  assign intop_end = (st_reg == EX_INTOP) && (cnt_reg == INTOP_CLKS - 2'h1);

  // Interrupt level seven cannot be masked
  assign irq_go = (irq_lvl > condition_code_reg[COND_MASK_LSB +: 3]) || (irq_lvl == 3'h7);
  assign take_async = (st_reg == EX_IDLE) && b_v && (bkpt_pend_reg || berr_pend_reg || irq_go);
  // Start only with the next word in A and PC six bytes past this instruction
  assign start_ok = (st_reg == EX_IDLE) && b_v && !take_async && a_v &&
                    (a_q[31:16] == b_q[31:16] + WORD_STEP) && (pc_reg == b_q[31:16] + PC_AHEAD);
  assign exc_go = take_async || (intop_end && sync_exc);
  assign b_retire = intop_end;

  // Priority: breakpoint, bus error, interrupt; synchronous causes arise only at instruction end
  always_comb begin
    async_vec = VEC_UNINIT;
    if (bkpt_pend_reg) begin
      async_vec = VEC_BKPT;
    end else if (berr_pend_reg) begin
      async_vec = VEC_BERR;
    end else if (IRQ_AUTOVEC) begin
      async_vec = VEC_AUTO_BASE + {5'h00, irq_lvl};
    end else if (IRQ_VEC >= USER_VEC_FIRST) begin
      async_vec = IRQ_VEC;
    end
  end

  // Synchronous exceptions add two so the return skips the faulting instruction
  always_comb begin
    exc_vec = async_vec;
    exc_stk = b_q[31:16] + PC_AHEAD;
    if (!take_async) begin
      exc_stk = b_q[31:16] + PC_AHEAD + SYNC_ADJ;
      if (is_swi) begin
        exc_vec = VEC_SWI;
      end else if (is_div) begin
        exc_vec = VEC_DIVZ;
      end else begin
        exc_vec = VEC_ILLEGAL;
      end
    end
  end

  // Program counter loads: reset PC word, jump target from stage A, fetched vector
  always_comb begin
    pc_load = 1'b0;
    pc_load_val = BUS_RDATA;
    if (st_reg == EX_RST_RD && ex_done && rst_idx_reg == 2'h1) begin
      pc_load = 1'b1;
    end else if (st_reg == EX_VEC_RD && ex_done) begin
      pc_load = 1'b1;
    end else if (intop_end && is_jmp && !exc_go) begin
      pc_load = 1'b1;
      pc_load_val = a_q[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution sequencer: reset vector, one instruction at a time, exception frames
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st_reg <= EX_RST_RD;
      rst_idx_reg <= 2'h0;
      cnt_reg <= 2'h0;
      ex_req_reg <= 1'b1;
      ex_we_reg <= 1'b0;
      ex_prog_reg <= 1'b1;
      ex_addr_reg <= RST_EXT_ADDR;
      ex_wdata_reg <= 16'h0000;
      vec_reg <= 8'h00;
      lvl_reg <= 3'h0;
      irq_take_reg <= 1'b0;
      condition_code_reg <= COND_RST;
      stack_pointer_reg <= 16'h0000;
      direct_page_index_reg <= 16'h0000;
      stack_bank_ext_reg <= 4'h0;
      z_index_bank_ext_reg <= 4'h0;
      EXC_TAKEN <= 1'b0;
    end else begin
      EXC_TAKEN <= 1'b0;
      if (exc_go) begin
        // Frame starts with the return PC at the current stack top
        st_reg <= EX_STK_PC;
        vec_reg <= exc_vec;
        lvl_reg <= irq_lvl;
        irq_take_reg <= take_async && !bkpt_pend_reg && !berr_pend_reg;
        ex_req_reg <= 1'b1;
        ex_we_reg <= 1'b1;
        ex_prog_reg <= 1'b0;
        ex_addr_reg <= {stack_bank_ext_reg, stack_pointer_reg};
        ex_wdata_reg <= exc_stk;
      end else begin
        case (st_reg)
          EX_RST_RD: begin
            if (ex_done) begin
              rst_idx_reg <= rst_idx_reg + 2'h1;
              case (rst_idx_reg)
                2'h0: begin
                  z_index_bank_ext_reg <= BUS_RDATA[EXT_ZBANK_LSB +: 4];
                  stack_bank_ext_reg <= BUS_RDATA[EXT_SBANK_LSB +: 4];
                  condition_code_reg[COND_PBANK_LSB +: 4] <= BUS_RDATA[EXT_PBANK_LSB +: 4];
                  ex_addr_reg <= RST_PC_ADDR;
                end
                2'h1: ex_addr_reg <= RST_STKP_ADDR;
                2'h2: begin
                  stack_pointer_reg <= BUS_RDATA;
                  ex_addr_reg <= RST_DPI_ADDR;
                end
                default: begin
                  direct_page_index_reg <= BUS_RDATA;
                  ex_req_reg <= 1'b0;
                  st_reg <= EX_IDLE;
                end
              endcase
            end
          end
          EX_IDLE: begin
            if (start_ok) begin
              st_reg <= EX_INTOP;
              cnt_reg <= 2'h0;
            end
          end
          EX_INTOP: begin
            if (intop_end) begin
              st_reg <= EX_IDLE;
              if (is_jmp) begin
                condition_code_reg[COND_PBANK_LSB +: 4] <= opnd[3:0];
              end
            end else begin
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
          EX_STK_PC: begin
            if (ex_done) begin
              stack_pointer_reg <= stack_pointer_reg - WORD_STEP;
              ex_addr_reg <= {stack_bank_ext_reg, stack_pointer_reg - WORD_STEP};
              ex_wdata_reg <= condition_code_reg;
              st_reg <= EX_STK_COND;
            end
          end
          EX_STK_COND: begin
            if (ex_done) begin
              stack_pointer_reg <= stack_pointer_reg - WORD_STEP;
              condition_code_reg[COND_PBANK_LSB +: 4] <= 4'h0;
              ex_we_reg <= 1'b0;
              ex_addr_reg <= {VEC_BANK, 7'h00, vec_reg, 1'b0};
              st_reg <= EX_VEC_RD;
            end
          end
          EX_VEC_RD: begin
            if (ex_done) begin
              ex_req_reg <= 1'b0;
              st_reg <= EX_IDLE;
              EXC_TAKEN <= 1'b1;
              if (irq_take_reg) begin
                condition_code_reg[COND_MASK_LSB +: 3] <= lvl_reg;
              end
            end
          end
          default: st_reg <= EX_IDLE;
        endcase
      end
    end
  end
  assign EXC_VECTOR = vec_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Tracking pins, active low, two phases: {B,A} = {fetch,start} then {advance,exception};
  // a purge shows as both low in the second phase. Events wait for their phase.
  assign ev = ev_reg | {purge, exc_go, a_to_b, start_ok, fetch_go};
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      phase_reg <= 1'b0;
      ev_reg <= 5'h00;
      track_a_reg <= 1'b1;
      track_b_reg <= 1'b1;
    end else begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        track_a_reg <= ~ev[1];
        track_b_reg <= ~ev[0];
        ev_reg <= ev & 5'h1C;
      end else begin
        ev_reg <= ev & 5'h03;
        track_a_reg <= ~ev[3] & ~ev[4];
        track_b_reg <= ~ev[2] & ~ev[4];
      end
    end
  end
  assign PIPE_TRACK_OUT_A = track_a_reg;
  assign PIPE_TRACK_OUT_B = track_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_bus_min_len: assert property ($rose(BUS_REQ) |=> BUS_REQ)
    else $error("bus cycle shorter than two clocks");
  a_intop_two: assert property ($rose(st_reg == EX_INTOP) |-> (st_reg == EX_INTOP)[*2] ##1 st_reg != EX_INTOP)
    else $error("internal operation not two clocks");
  a_exec_pc: assert property ($rose(st_reg == EX_INTOP) |-> pc_reg == b_q[31:16] + PC_AHEAD)
    else $error("pc not six ahead at start");
  a_flow_purge: assert property (pc_load |=> !a_v && !b_v && !hold_v_reg)
    else $error("old stream not purged");
  a_vec_table: assert property (BUS_REQ && st_reg == EX_VEC_RD |-> !BUS_PROG && !BUS_WE && BUS_ADDR < VEC_TABLE_BYTES)
    else $error("vector read outside table");
  a_vec_shift: assert property (BUS_REQ && st_reg == EX_VEC_RD |-> BUS_ADDR[8:1] == vec_reg && !BUS_ADDR[0])
    else $error("vector address not number times two");
  a_reset_fetch: assert property ($fell(RESET) |-> ##[0:2] (BUS_REQ && BUS_PROG && BUS_ADDR == RST_EXT_ADDR))
    else $error("reset vector not read first");
  a_autovec: assert property (take_async && !bkpt_pend_reg && !berr_pend_reg && IRQ_AUTOVEC |=> vec_reg == $past(irq_lvl) + VEC_AUTO_BASE)
    else $error("wrong autovector");
  // A prefetch still in flight when the frame starts is not part of the frame
  a_stack_frame: assert property (BUS_REQ && !bus_fetch_reg && st_reg == EX_STK_PC |->
    BUS_WE && BUS_ADDR == {stack_bank_ext_reg, stack_pointer_reg})
    else $error("pc not pushed at stack pointer");
  a_pbank_clear: assert property (st_reg == EX_VEC_RD |-> condition_code_reg[COND_PBANK_LSB +: 4] == 4'h0)
    else $error("program bank not cleared");
  a_stage_c: assert property (b_retire |=> c_v && c_q == $past(b_q))
    else $error("finished opcode not in stage C");
endmodule // cpev_core

// file: cpev_pkg.sv
// Shared constants for the core fetch, pipeline and exception-vectoring block.
// Assumes a single 250 MHz clock and a bus integration module on the same clock.
package cpev_pkg;
  localparam int AW = 20;
  localparam int DW = 16;
  localparam int STW = AW + DW;
  // Bus and internal-operation timing, in clock periods
  localparam logic [2:0] BUS_MIN_CLKS = 3'h2;
  localparam logic [1:0] INTOP_CLKS = 2'h2;
  // Program counter offsets
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] PC_AHEAD = 16'h0006;
  localparam logic [15:0] SYNC_ADJ = 16'h0002;
  // Reset fetch addresses, program space
  localparam logic [19:0] RST_EXT_ADDR = 20'h0_0000;
  localparam logic [19:0] RST_PC_ADDR = 20'h0_0002;
  localparam logic [19:0] RST_STKP_ADDR = 20'h0_0004;
  localparam logic [19:0] RST_DPI_ADDR = 20'h0_0006;
  // Vector table
  localparam logic [19:0] VEC_TABLE_BYTES = 20'h0_0200;
  localparam logic [3:0] VEC_BANK = 4'h0;
  localparam int NUM_PREDEF_VEC = 52;
  localparam int NUM_USER_VEC = 200;
  localparam logic [7:0] VEC_BKPT = 8'h04;
  localparam logic [7:0] VEC_BERR = 8'h05;
  localparam logic [7:0] VEC_SWI = 8'h06;
  localparam logic [7:0] VEC_ILLEGAL = 8'h07;
  localparam logic [7:0] VEC_DIVZ = 8'h08;
  localparam logic [7:0] VEC_UNINIT = 8'h0F;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h10;
  localparam logic [7:0] USER_VEC_FIRST = 8'h38;
  // Field positions in the reset extension word and condition codes
  localparam int EXT_PBANK_LSB = 0;
  localparam int EXT_SBANK_LSB = 4;
  localparam int EXT_ZBANK_LSB = 8;
  localparam int COND_PBANK_LSB = 0;
  localparam int COND_MASK_LSB = 5;
  localparam logic [15:0] COND_RST = 16'h00E0;
  // Opcodes understood by the execution unit
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_JMP = 8'h01;
  localparam logic [7:0] OP_SWI = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  // Input pin synchroniser reset level (breakpoint and bus error inactive, level zero)
  localparam logic [4:0] PIN_RST = 5'h18;
  typedef enum logic [2:0] {
    EX_RST_RD, EX_IDLE, EX_INTOP, EX_STK_PC, EX_STK_COND, EX_VEC_RD
  } cpev_ex_e;
endpackage

// file: cpev_stage.sv
// One pipeline stage: a word with its address and a valid flag.
// Assumes clear has priority over load, and load over take.
`timescale 1ns/1ps
module cpev_stage #(
  parameter int W = 36
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic load,
  input wire logic take,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic valid
);
  // Data only moves on load, so a purged stage keeps stale bits but reads invalid
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      valid <= 1'b0;
    end else if (clr) begin
      valid <= 1'b0;
    end else if (load) begin
      q <= d;
      valid <= 1'b1;
    end else if (take) begin
      valid <= 1'b0;
    end
  end
endmodule // cpev_stage

// file: cpev_mem_model.sv
// Bus partner: a word memory that answers the core's bus cycles.
// Assumes it shares the core clock; the bench sets the wait states.
`timescale 1ns/1ps
module cpev_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] wait_clks,
  input wire logic req,
  input wire logic we,
  input wire logic [cpev_pkg::AW-1:0] addr,
  input wire logic [cpev_pkg::DW-1:0] wdata,
  output logic [cpev_pkg::DW-1:0] rdata,
  output logic ack
);
  import cpev_pkg::*;
  logic [DW-1:0] mem [0:2047];
  logic [3:0] age_reg;
  ////////////////////////////////////////////////////////////////
  // Reset words, vectors and a tiny program; the rest is NOP
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 16'h0000;
    mem[1] = 16'h0100;
    mem[2] = 16'h0800;
    mem[3] = 16'h1234;
    mem[6] = 16'h0200;
    mem[7] = 16'h0300;
    mem[8'h17] = 16'h0300;
    mem[8'h40] = 16'h0300;
    mem[11'h080] = 16'h0200; // Software interrupt at 0100
    mem[11'h100] = 16'hFF00; // Undefined opcode at 0200
  end
  ////////////////////////////////////////////////////////////////
  // Never acks in the first clock of a cycle; wait states stretch it
  always_ff @(posedge clk) begin
    if (rst || ack) begin
      ack <= 1'b0;
      age_reg <= 4'h0;
    end else if (req) begin
      age_reg <= age_reg + 4'h1;
      ack <= (age_reg >= wait_clks);
    end
  end
  // Read data is valid only with ack; inverted otherwise so stale data never matches
  always @(posedge clk) begin
    if (rst) rdata <= 16'h0000;
    else if (req && !ack && age_reg >= wait_clks) rdata <= mem[addr[11:1]];
    else rdata <= ~rdata;
    if (req && ack && we) mem[addr[11:1]] <= wdata;
  end
endmodule // cpev_mem_model

// file: tb_top.sv
// Self-checking bench for the core: reset reads, fetch, exception frames and vectors.
// Assumes cpev_pkg, cpev_core and cpev_mem_model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import cpev_pkg::*;
  logic MCLK, RESET, BUS_REQ, BUS_WE, BUS_PROG, BUS_ACK, BKPT_N, BERR_N, IRQ_AUTOVEC;
  logic PIPE_TRACK_OUT_A, PIPE_TRACK_OUT_B, EXC_TAKEN;
  logic [AW-1:0] BUS_ADDR;
  logic [DW-1:0] BUS_WDATA, BUS_RDATA;
  logic [2:0] IRQ_LEVEL;
  logic [7:0] IRQ_VEC, EXC_VECTOR, taken_vec;
  logic [3:0] wait_clks;
  logic [37:0] log_q [$];
  int mismatches, n_compared, n_taken, n_trk_a, n_trk_b;
  ////////////////////////////////////////////////////////////////
  cpev_core uut (.MCLK(MCLK), .RESET(RESET), .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE), .BUS_PROG(BUS_PROG),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK),
    .BKPT_N(BKPT_N), .BERR_N(BERR_N), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_VEC(IRQ_VEC),
    .IRQ_AUTOVEC(IRQ_AUTOVEC), .PIPE_TRACK_OUT_A(PIPE_TRACK_OUT_A),
    .PIPE_TRACK_OUT_B(PIPE_TRACK_OUT_B), .EXC_TAKEN(EXC_TAKEN), .EXC_VECTOR(EXC_VECTOR));
  cpev_mem_model mem_u (.clk(MCLK), .rst(RESET), .wait_clks(wait_clks), .req(BUS_REQ), .we(BUS_WE),
    .addr(BUS_ADDR), .wdata(BUS_WDATA), .rdata(BUS_RDATA), .ack(BUS_ACK));
  ////////////////////////////////////////////////////////////////
  // Log every completed bus cycle as {we, prog, addr, wdata}, and each taken exception
  always @(posedge MCLK) begin
    if (BUS_REQ === 1'b1 && BUS_ACK === 1'b1) log_q.push_back({BUS_WE, BUS_PROG, BUS_ADDR, BUS_WDATA});
    if (PIPE_TRACK_OUT_A === 1'b0) n_trk_a++;
    if (PIPE_TRACK_OUT_B === 1'b0) n_trk_b++;
    if (EXC_TAKEN === 1'b1) begin
      n_taken++;
      taken_vec = EXC_VECTOR;
    end
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [37:0] exp, input logic [37:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Next logged cycle, optionally skipping instruction fetches; bounded wait
  task automatic expect_cyc(input string what, input bit skip, input logic [21:0] hdr, input logic [15:0] d,
                            input bit chk_d);
    logic [37:0] e;
    for (int i = 0; i < 400; i++) begin
      while (log_q.size() > 0) begin
        e = log_q.pop_front();
        if (!(skip && e[37:36] == 2'b01)) begin
          check(what, {hdr, chk_d ? d : 16'h0000}, {e[37:16], chk_d ? e[15:0] : 16'h0000});
          return;
        end
      end
      @(negedge MCLK);
    end
    mismatches++;
    $display("mismatch %s expected bus cycle seen none", what);
    give_verdict();
  endtask
  ////////////////////////////////////////////////////////////////
  // Four program-space reset words in order, then the first fetch from the reset PC
  task automatic test_reset_reads();
    for (int k = 0; k < 4; k++) expect_cyc("reset read", 0, {2'b01, 20'(2 * k)}, 16'h0000, 0);
    expect_cyc("first fetch", 0, {2'b01, 20'h0_0100}, 16'h0000, 0);
    $display("test reset_reads done");
  endtask
  // Frame pushes at the stack pointer, then a data-space vector read at number times two
  task automatic expect_exc(input logic [7:0] vec, input logic [15:0] stk, input logic [15:0] pc, input bit chk_pc,
                            input bit chk_cond);
    int seen;
    seen = n_taken;
    expect_cyc("stacked pc", 1, {2'b10, 4'h0, stk}, pc, chk_pc);
    @(negedge MCLK);
    IRQ_LEVEL = 3'h0;
    expect_cyc("stacked flags", 1, {2'b10, 4'h0, stk - 16'h0002}, COND_RST, chk_cond);
    expect_cyc("vector read", 1, {2'b00, VEC_BANK, 7'h00, vec, 1'b0}, 16'h0000, 0);
    for (int i = 0; i < 100 && n_taken == seen; i++) @(negedge MCLK);
    check("exception taken", 38'h1, 38'(n_taken != seen));
    check("exception vector", 38'(vec), 38'(taken_vec));
    if (n_taken == seen) give_verdict();
    $display("test exception %h done", vec);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  // Main sequence: inputs move at falling edges only
  initial begin
    RESET = 1'b1;
    BKPT_N = 1'b1;
    BERR_N = 1'b1;
    IRQ_LEVEL = 3'h0;
    IRQ_VEC = 8'h00;
    IRQ_AUTOVEC = 1'b0;
    wait_clks = 4'h0;
    repeat (8) @(negedge MCLK);
    check("tracking pins in reset", 38'h3, 38'({PIPE_TRACK_OUT_B, PIPE_TRACK_OUT_A}));
    RESET = 1'b0;
    test_reset_reads();
    expect_exc(VEC_SWI, 16'h0800, 16'h0108, 1, 1);
    expect_exc(VEC_ILLEGAL, 16'h07FC, 16'h0208, 1, 1);
    // Slow memory from here on, and interrupts: an autovector, then a vector on IRQ_VEC
    wait_clks = 4'h3;
    IRQ_AUTOVEC = 1'b1;
    IRQ_LEVEL = 3'h7;
    expect_exc(8'h17, 16'h07F8, 16'h0000, 0, 1);
    IRQ_AUTOVEC = 1'b0;
    IRQ_VEC = USER_VEC_FIRST + 8'h08;
    IRQ_LEVEL = 3'h7;
    expect_exc(8'h40, 16'h07F4, 16'h0000, 0, 1);
    // Both tracking pins must have gone low at least once, in either phase, by now
    check("tracking pins active", 38'h3, 38'({n_trk_b > 0, n_trk_a > 0}));
    give_verdict();
  end
endmodule // tb_top
